// ==== pkg/flash_pkg.sv ====
// Purpose: shared constants of the flash write-enable/status link
// Assumes: 25 MHz core clock
// Notes:   opcodes, status layout, busy times, host register map
`default_nettype none
package flash_pkg;
	// ----------------------------------------------------------------
	// opcodes
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_LATCH_SET   = 8'h06;
	localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
	localparam logic [7:0] OP_STATUS_READ = 8'h05;
	localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
	localparam logic [7:0] OP_PAGE_WRITE  = 8'h02;
	localparam logic [7:0] OP_QUAD_PAGE   = 8'h38;
	localparam logic [7:0] OP_SMALL_ERASE = 8'h20;
	localparam logic [7:0] OP_HALF_ERASE  = 8'h52;
	localparam logic [7:0] OP_FULL_ERASE  = 8'hd8;
	localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
	localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
	localparam logic [7:0] OP_IDENT_READ  = 8'h9f;
	localparam logic [7:0] OP_SUSPEND     = 8'hb0;
	localparam logic [7:0] OP_RESUME      = 8'h30;
	localparam logic [7:0] OP_QUAD_ENTER  = 8'h35;
	localparam logic [7:0] OP_QUAD_EXIT   = 8'hf5;
	// ----------------------------------------------------------------
	// status byte layout
	// ----------------------------------------------------------------
	localparam int         BUSY_BIT   = 0;
	localparam int         WEL_BIT    = 1;
	localparam int         BP_LSB     = 2;
	localparam int         QE_BIT     = 6;
	localparam int         LOCK_BIT   = 7;
	localparam logic [7:0] STATUS_RST = 8'h00;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ        = 25;
	localparam int PAGE_TIME_US   = 300;
	localparam int SECTOR_TIME_US = 40000;
	localparam int HALF_TIME_US   = 80000;
	localparam int BLOCK_TIME_US  = 120000;
	localparam int CHIP_TIME_US   = 12000000;
	localparam int STAT_TIME_US   = 5000;
	localparam int PAGE_CYC       = PAGE_TIME_US * CLK_MHZ;
	localparam int SECTOR_CYC     = SECTOR_TIME_US * CLK_MHZ;
	localparam int HALF_CYC       = HALF_TIME_US * CLK_MHZ;
	localparam int BLOCK_CYC      = BLOCK_TIME_US * CLK_MHZ;
	localparam int CHIP_CYC       = CHIP_TIME_US * CLK_MHZ;
	localparam int STAT_CYC       = STAT_TIME_US * CLK_MHZ;
	localparam logic [3:0] SCLK_HALF = 4'h8;
	// ----------------------------------------------------------------
	// host register map and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CMD  = 8'h00;
	localparam logic [7:0] REG_TXD  = 8'h04;
	localparam logic [7:0] REG_RXD  = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0c;
	localparam int CMD_NTX_LSB = 8;
	localparam int CMD_NRX_LSB = 11;
	localparam int CMD_QUAD    = 13;
	localparam int CMD_POLL    = 14;
	localparam int CMD_AUTO    = 15;
	localparam int STAT_WP     = 1;
endpackage
`default_nettype wire

// ==== pkg/flash_link_if.sv ====
// Purpose: serial link between flash controller and flash device
// Assumes: io lines resolved here from both enables
// Notes:   undriven io lines read high (pull-up)
`timescale 1ns/10ps
`default_nettype none
interface flash_link_if;
	logic       sclk;
	logic       sel_n;
	logic       wp_n;
	logic [3:0] h_io_out;
	logic [3:0] h_io_oe;
	logic [3:0] d_io_out;
	logic [3:0] d_io_oe;
	logic [3:0] io;

	assign io = (d_io_oe & d_io_out) |
		(~d_io_oe & h_io_oe & h_io_out) | (~d_io_oe & ~h_io_oe);

	modport host (
		output sclk, sel_n, wp_n, h_io_out, h_io_oe,
		input  io
	);
	modport flash (
		input  sclk, sel_n, wp_n, io,
		output d_io_out, d_io_oe
	);
endinterface
`default_nettype wire

// ==== hdl/sync_pipe.sv ====
// Purpose: two-stage synchroniser with a third stage for edges
// Assumes: inputs asynchronous to clk_in
// Notes:   first stage read only by second stage
`timescale 1ns/10ps
`default_nettype none
module sync_pipe #(
	parameter int         W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out,
	output logic      [W-1:0] q_prev_out
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			meta_q     <= RST_VAL;
			q_out      <= RST_VAL;
			q_prev_out <= RST_VAL;
		end else begin
			meta_q     <= d_in;
			q_out      <= meta_q;
			q_prev_out <= q_out;
		end
	end
endmodule
`default_nettype wire

// ==== hdl/flash_wel_status_dev.sv ====
// Purpose: flash device end: write-enable latch, status, identification
// Assumes: link pins sampled by core clock, sclk mode 0
// Notes:   array program/erase modelled as busy timers only
`timescale 1ns/10ps
`default_nettype none
module flash_wel_status_dev #(
	parameter int          PAGE_T   = flash_pkg::PAGE_CYC,
	parameter int          SECTOR_T = flash_pkg::SECTOR_CYC,
	parameter int          HALF_T   = flash_pkg::HALF_CYC,
	parameter int          BLOCK_T  = flash_pkg::BLOCK_CYC,
	parameter int          CHIP_T   = flash_pkg::CHIP_CYC,
	parameter int          STAT_T   = flash_pkg::STAT_CYC,
	// identification values are arbitrary
	parameter logic [7:0]  MFR_ID   = 8'h5a,
	parameter logic [15:0] DEV_ID   = 16'h1234
) (
	// clock and reset
	input  wire logic       core_clk_in,
	input  wire logic       sys_rst_in,
	// serial link
	flash_link_if.flash     link,
	// user side
	output logic [7:0]      status_out,
	output logic            quad_mode_out
);
	import flash_pkg::*;

	typedef enum {OUT_NONE, OUT_STATUS, OUT_IDENT} out_mode_t;

	// ----------------------------------------------------------------
	// pin sampling
	// ----------------------------------------------------------------
	logic [6:0] sy;
	logic [6:0] sy_p;
	logic       sclk_rise;
	logic       sclk_fall;
	logic       frame_end;

	sync_pipe #(.W(7), .RST_VAL(7'h60)) u_sync (
		.clk_in     (core_clk_in),
		.rst_in     (sys_rst_in),
		.d_in       ({link.wp_n, link.sel_n, link.sclk, link.io}),
		.q_out      (sy),
		.q_prev_out (sy_p)
	);

	assign sclk_rise = sy[4] & ~sy_p[4] & ~sy[5];
	assign sclk_fall = ~sy[4] & sy_p[4] & ~sy[5];
	assign frame_end = sy[5] & ~sy_p[5];

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic        quad_q;
	logic [7:0]  shift_q;
	logic [2:0]  bit_q;
	logic [2:0]  byte_q;
	logic [7:0]  op_q;
	logic [23:0] addr_q;
	logic [7:0]  wdat_q;
	out_mode_t   out_mode_q;
	logic [23:0] out_sh_q;
	logic [2:0]  out_pos_q;
	logic [3:0]  io_out_q;
	logic [3:0]  io_oe_q;
	logic        wel_q;
	logic        busy_q;
	logic        susp_q;
	logic [31:0] cnt_q;
	logic [3:0]  bp_q;
	logic        qe_q;
	logic        lock_q;

	logic [3:0]  bit_nx;
	logic [7:0]  new_byte;
	logic        byte_done;
	logic [7:0]  stat;
	logic        hardware_lock_mode;
	logic        prot;
	logic        one;
	logic        set_wel;
	logic        clr_wel;
	logic        start;
	logic [31:0] start_cyc;
	logic        wr_stat;
	logic        susp_ev;
	logic        resume_ev;
	logic        quad_on;
	logic        quad_off;
	logic        op_done;
	logic [23:0] cur;

	// status byte, busy and latch at bits 0 and 1
	assign stat = {lock_q, qe_q, bp_q, wel_q, busy_q};
	// hardware lock, off with quad-enhance or quad mode
	assign hardware_lock_mode  = lock_q & ~sy[6] & ~qe_q & ~quad_q;
	assign prot = (bp_q != 4'h0) &&
		({1'b0, addr_q[23:20]} >= (5'd16 - {1'b0, bp_q}));
	assign one  = (byte_q == 3'd1);
	// upper lines ignored in single-line mode
	assign bit_nx    = {1'b0, bit_q} + (quad_q ? 4'd4 : 4'd1);
	assign new_byte  = quad_q ? {shift_q[3:0], sy[3:0]} :
		{shift_q[6:0], sy[0]};
	assign byte_done = sclk_rise & bit_nx[3];
	assign op_done   = busy_q & (cnt_q == 32'h1) & ~susp_ev;

	// ----------------------------------------------------------------
	// command shifter
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			shift_q <= 8'h00;
			bit_q   <= 3'h0;
			byte_q  <= 3'h0;
			op_q    <= 8'h00;
			addr_q  <= 24'h0;
			wdat_q  <= 8'h00;
		end else if (sy[5]) begin
			bit_q  <= 3'h0;
			byte_q <= 3'h0;
		end else if (sclk_rise) begin
			shift_q <= new_byte;
			bit_q   <= bit_nx[2:0];
			if (byte_done) begin
				if (byte_q != 3'd7)
					byte_q <= byte_q + 3'd1;
				if (byte_q == 3'd0)
					op_q <= new_byte;
				else if (byte_q <= 3'd3)
					addr_q <= {addr_q[15:0], new_byte};
				if (byte_q == 3'd1)
					wdat_q <= new_byte;
			end
		end
	end

	// ----------------------------------------------------------------
	// end-of-frame decode
	// ----------------------------------------------------------------
	always_comb begin
		set_wel   = 1'b0;
		clr_wel   = 1'b0;
		start     = 1'b0;
		start_cyc = 32'h0;
		wr_stat   = 1'b0;
		susp_ev   = 1'b0;
		resume_ev = 1'b0;
		quad_on   = 1'b0;
		quad_off  = 1'b0;
		// acted on only at a byte boundary
		if (frame_end && bit_q == 3'h0) begin
			if (busy_q) begin
				if (op_q == OP_SUSPEND && one)
					susp_ev = 1'b1;
			end else begin
				case (op_q)
				OP_LATCH_SET: set_wel = one;
				OP_LATCH_CLEAR: clr_wel = one;
				OP_QUAD_ENTER: quad_on = one;
				OP_QUAD_EXIT: quad_off = one;
				OP_RESUME: resume_ev = one & susp_q;
				OP_STATUS_WRITE: begin
					wr_stat   = (byte_q == 3'd2) & wel_q & ~hardware_lock_mode;
					start     = wr_stat;
					start_cyc = 32'(STAT_T);
				end
				OP_PAGE_WRITE, OP_QUAD_PAGE: begin
					start     = (byte_q >= 3'd5) & wel_q & ~prot;
					start_cyc = 32'(PAGE_T);
				end
				OP_SMALL_ERASE: begin
					start     = (byte_q == 3'd4) & wel_q & ~prot;
					start_cyc = 32'(SECTOR_T);
				end
				OP_HALF_ERASE: begin
					start     = (byte_q == 3'd4) & wel_q & ~prot;
					start_cyc = 32'(HALF_T);
				end
				OP_FULL_ERASE: begin
					start     = (byte_q == 3'd4) & wel_q & ~prot;
					start_cyc = 32'(BLOCK_T);
				end
				OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: begin
					start     = one & wel_q & (bp_q == 4'h0);
					start_cyc = 32'(CHIP_T);
				end
				default: start = 1'b0;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// busy timer and suspend
	// ----------------------------------------------------------------
	// busy while an operation runs
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			busy_q <= 1'b0;
			susp_q <= 1'b0;
			cnt_q  <= 32'h0;
		end else if (start) begin
			busy_q <= 1'b1;
			susp_q <= 1'b0;
			cnt_q  <= start_cyc;
		end else if (susp_ev) begin
			busy_q <= 1'b0;
			susp_q <= 1'b1;
		end else if (resume_ev) begin
			busy_q <= 1'b1;
			susp_q <= 1'b0;
		end else if (busy_q) begin
			cnt_q <= cnt_q - 32'h1;
			if (op_done)
				busy_q <= 1'b0;
		end
	end

	// latch cleared on completion and suspend
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			wel_q <= 1'b0;
		else if (clr_wel || op_done || susp_ev)
			wel_q <= 1'b0;
		else if (set_wel)
			wel_q <= 1'b1;
	end

	// status write touches bits 7..2 only
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			bp_q   <= STATUS_RST[BP_LSB +: 4];
			qe_q   <= STATUS_RST[QE_BIT];
			lock_q <= STATUS_RST[LOCK_BIT];
		end else if (wr_stat) begin
			bp_q   <= wdat_q[BP_LSB +: 4];
			qe_q   <= wdat_q[QE_BIT];
			lock_q <= wdat_q[LOCK_BIT];
		end
	end

	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			quad_q <= 1'b0;
		else if (quad_on)
			quad_q <= 1'b1;
		else if (quad_off)
			quad_q <= 1'b0;
	end

	// ----------------------------------------------------------------
	// readout
	// ----------------------------------------------------------------
	// status reloaded at each byte start
	always_comb begin
		cur = out_sh_q;
		if (out_mode_q == OUT_STATUS && out_pos_q == 3'h0)
			cur = {stat, 16'h0};
	end

	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			out_mode_q <= OUT_NONE;
			out_sh_q   <= 24'h0;
			out_pos_q  <= 3'h0;
			io_out_q   <= 4'h0;
			io_oe_q    <= 4'h0;
		end else if (sy[5]) begin
			out_mode_q <= OUT_NONE;
			io_oe_q    <= 4'h0;
		end else if (byte_done && byte_q == 3'd0) begin
			out_pos_q <= 3'h0;
			if (new_byte == OP_STATUS_READ)
				out_mode_q <= OUT_STATUS;
			else if (new_byte == OP_IDENT_READ && !busy_q && !quad_q) begin
				out_mode_q <= OUT_IDENT;
				out_sh_q   <= {MFR_ID, DEV_ID};
			end
		end else if (sclk_fall && out_mode_q != OUT_NONE) begin
			if (quad_q) begin
				io_out_q  <= cur[23:20];
				io_oe_q   <= 4'hf;
				out_sh_q  <= {cur[19:0], 4'h0};
				out_pos_q <= out_pos_q + 3'd4;
			end else begin
				io_out_q  <= {2'b00, cur[23], 1'b0};
				io_oe_q   <= 4'h2;
				out_sh_q  <= {cur[22:0], 1'b0};
				out_pos_q <= out_pos_q + 3'd1;
			end
		end
	end

	assign link.d_io_out = io_out_q;
	assign link.d_io_oe  = io_oe_q;
	assign status_out    = {lock_q, qe_q, bp_q, wel_q, busy_q};
	assign quad_mode_out = quad_q;
endmodule
`default_nettype wire

// ==== hdl/flash_host_ctrl.sv ====
// Purpose: flash controller end with AXI4-Lite command registers
// Assumes: single master, one write and one read outstanding
// Notes:   serial clock made by divider, high for two SCLK_HALF steps, low for one
`timescale 1ns/10ps
`default_nettype none
module flash_host_ctrl (
	// clock and reset
	input  wire logic       core_clk_in,
	input  wire logic       sys_rst_in,
	// axi4-lite slave
	input  wire logic [7:0] s_axi_awaddr,
	input  wire logic       s_axi_awvalid,
	output logic            s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0] s_axi_wstrb,
	input  wire logic       s_axi_wvalid,
	output logic            s_axi_wready,
	output logic [1:0]      s_axi_bresp,
	output logic            s_axi_bvalid,
	input  wire logic       s_axi_bready,
	input  wire logic [7:0] s_axi_araddr,
	input  wire logic       s_axi_arvalid,
	output logic            s_axi_arready,
	output logic [31:0]     s_axi_rdata,
	output logic [1:0]      s_axi_rresp,
	output logic            s_axi_rvalid,
	input  wire logic       s_axi_rready,
	// serial link
	flash_link_if.host      link
);
	import flash_pkg::*;

	typedef enum {H_IDLE, H_SEL, H_HI, H_LO, H_END, H_GAP} hst_t;

	logic [7:0]  aw_q;
	logic [31:0] wd_q;
	logic [3:0]  ws_q;
	logic        aw_has_q;
	logic        w_has_q;
	logic [15:0] cmd_q;
	logic [31:0] txd_q;
	logic [31:0] rx_q;
	logic        wp_q;
	logic [31:0] wmask;
	logic        wr_go;
	logic        go;
	logic        busy;
	logic        go_q;
	logic        again;
	hst_t        st_q;
	logic [3:0]  div_q;
	logic [39:0] sh_q;
	logic [6:0]  clk_left_q;
	logic [6:0]  tx_left_q;
	logic [6:0]  rxc_q;
	logic        pre_q;
	logic        sclk_q;
	logic        sel_n_q;
	logic [3:0]  io_out_q;
	logic [3:0]  io_oe_q;
	logic [3:0]  io_s;
	logic [3:0]  mask;
	logic [39:0] fr;
	logic [6:0]  txc;
	logic [6:0]  rxc;
	logic        quad;

	sync_pipe #(.W(4), .RST_VAL(4'hf)) u_sync (
		.clk_in     (core_clk_in),
		.rst_in     (sys_rst_in),
		.d_in       (link.io),
		.q_out      (io_s),
		.q_prev_out ()
	);

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	assign wr_go = aw_has_q & w_has_q & ~s_axi_bvalid;
	assign again = cmd_q[CMD_POLL] & rx_q[BUSY_BIT] & (rxc_q != 7'd0);
	// pending start, latch-set lead-in or poll repeat counts as active
	assign busy  = (st_q != H_IDLE) | go_q | pre_q | again;
	assign go    = wr_go & (aw_q == REG_CMD) & ~busy;
	assign wmask = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};

	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			aw_q <= 8'h00;
			wd_q <= 32'h0;
			ws_q <= 4'h0;
			aw_has_q <= 1'b0;
			w_has_q  <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
			cmd_q <= 16'h0;
			txd_q <= 32'h0;
			wp_q  <= 1'b1;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q <= s_axi_awaddr;
				aw_has_q <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wd_q <= s_axi_wdata;
				ws_q <= s_axi_wstrb;
				w_has_q <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				aw_has_q <= 1'b0;
				w_has_q  <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= 2'b00;
				if (aw_q == REG_CMD) begin
					if (!busy)
						cmd_q <= (cmd_q & ~wmask[15:0]) | (wd_q[15:0] & wmask[15:0]);
				end else if (aw_q == REG_TXD)
					txd_q <= (txd_q & ~wmask) | (wd_q & wmask);
				else if (aw_q == REG_STAT) begin
					if (ws_q[0])
						wp_q <= wd_q[STAT_WP];
				end else if (aw_q != REG_RXD)
					s_axi_bresp <= 2'b10;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= 2'b00;
			if (s_axi_araddr == REG_CMD)
				s_axi_rdata <= {16'h0, cmd_q};
			else if (s_axi_araddr == REG_TXD)
				s_axi_rdata <= txd_q;
			else if (s_axi_araddr == REG_RXD)
				s_axi_rdata <= rx_q;
			else if (s_axi_araddr == REG_STAT)
				s_axi_rdata <= {30'h0, wp_q, busy};
			else begin
				s_axi_rdata <= 32'h0;
				s_axi_rresp <= 2'b10;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// serial engine
	// ----------------------------------------------------------------
	assign quad = cmd_q[CMD_QUAD];
	assign mask = quad ? 4'hf : 4'h1;
	// optional latch-set frame ahead of the command
	assign fr   = (go_q && cmd_q[CMD_AUTO]) ?
		{OP_LATCH_SET, 32'h0} : {cmd_q[7:0], txd_q};
	assign txc  = (go_q && cmd_q[CMD_AUTO]) ? (quad ? 7'd2 : 7'd8) :
		(quad ? 7'd2 : 7'd8) * (7'd1 + {4'h0, cmd_q[CMD_NTX_LSB +: 3]});
	assign rxc  = (go_q && cmd_q[CMD_AUTO]) ? 7'd0 :
		(quad ? 7'd2 : 7'd8) * {5'h0, cmd_q[CMD_NRX_LSB +: 2]};

	// start held until cmd_q is loaded and the engine takes it
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			go_q <= 1'b0;
		else if (go)
			go_q <= 1'b1;
		else if (st_q == H_IDLE && div_q == 4'h0)
			go_q <= 1'b0;
	end

	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			st_q <= H_IDLE;
			div_q <= 4'h0;
			sh_q <= 40'h0;
			clk_left_q <= 7'h0;
			tx_left_q <= 7'h0;
			rxc_q <= 7'h0;
			pre_q <= 1'b0;
			sclk_q <= 1'b0;
			sel_n_q <= 1'b1;
			io_out_q <= 4'h0;
			io_oe_q <= 4'h0;
			rx_q <= 32'h0;
		end else if (div_q != 4'h0) begin
			div_q <= div_q - 4'h1;
		end else begin
			div_q <= SCLK_HALF - 4'h1;
			case (st_q)
			// poll repeats while busy bit reads one
			H_IDLE: if (go_q || pre_q || again) begin
				st_q <= H_SEL;
				pre_q <= go_q & cmd_q[CMD_AUTO];
				sel_n_q <= 1'b0;
				io_out_q <= quad ? fr[39:36] : {3'h0, fr[39]};
				io_oe_q <= mask;
				sh_q <= quad ? {fr[35:0], 4'h0} : {fr[38:0], 1'b0};
				clk_left_q <= txc + rxc;
				tx_left_q <= txc - 7'd1;
				rxc_q <= rxc;
			end else
				div_q <= 4'h0;
			H_SEL: begin
				st_q <= H_HI;
				sclk_q <= 1'b1;
			end
			H_HI: begin
				if (clk_left_q <= rxc_q)
					rx_q <= quad ? {rx_q[27:0], io_s} : {rx_q[30:0], io_s[1]};
				clk_left_q <= clk_left_q - 7'd1;
				st_q <= H_LO;
			end
			H_LO: begin
				sclk_q <= 1'b0;
				io_out_q <= quad ? sh_q[39:36] : {3'h0, sh_q[39]};
				io_oe_q <= (tx_left_q != 7'd0) ? mask : 4'h0;
				sh_q <= quad ? {sh_q[35:0], 4'h0} : {sh_q[38:0], 1'b0};
				if (tx_left_q != 7'd0)
					tx_left_q <= tx_left_q - 7'd1;
				st_q <= (clk_left_q == 7'd0) ? H_END : H_SEL;
			end
			H_END: begin
				sel_n_q <= 1'b1;
				io_oe_q <= 4'h0;
				st_q <= H_GAP;
			end
			// gap over, back to idle
			default: st_q <= H_IDLE;
			endcase
		end
	end

	assign link.sclk     = sclk_q;
	assign link.sel_n    = sel_n_q;
	assign link.wp_n     = wp_q;
	assign link.h_io_out = io_out_q;
	assign link.h_io_oe  = io_oe_q;
endmodule
`default_nettype wire

// ==== verification/flash_link_monitor.sv ====
// Purpose: link and status checks
// Assumes: one core clock
// Notes:   watches the shared link
`timescale 1ns/10ps
`default_nettype none
module flash_link_monitor (
	// clock and reset
	input wire logic       core_clk_in,
	input wire logic       sys_rst_in,
	// link
	input wire logic       sel_n,
	input wire logic       wp_n,
	input wire logic [3:0] d_io_oe,
	// device side
	input wire logic [7:0] status_out,
	input wire logic       quad_mode_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);
	wire logic hw_lock;
	assign hw_lock = status_out[7] & ~wp_n & ~status_out[6] & ~quad_mode_out;
	sel_release_a: assert property ($rose(sel_n) |-> ##[1:6] !d_io_oe)
		else $error("io held after select");
	idle_quiet_a: assert property (sel_n [*8] |-> d_io_oe == 4'h0)
		else $error("io driven while idle");
	spi_lane_a: assert property (!quad_mode_out && d_io_oe != 4'h0
		|-> d_io_oe == 4'h2) else $error("wrong output lane");
	wel_at_end_a: assert property ($rose(status_out[1]) |-> sel_n)
		else $error("latch set inside frame");
	bp_at_end_a: assert property ($changed(status_out[5:2])
		|-> sel_n && $past(status_out[1])) else $error("bp change");
	lock_hold_a: assert property (hw_lock && $past(hw_lock)
		|-> $stable({status_out[7], status_out[5:2]}))
		else $error("locked bits changed");
	done_clears_a: assert property ($fell(status_out[0])
		|-> !status_out[1]) else $error("latch kept after op");
	busy_at_end_a: assert property ($rose(status_out[0]) |-> sel_n)
		else $error("busy inside frame");
	cover property ($rose(status_out[0]));
	cover property ($rose(status_out[1]));
	cover property (hw_lock);
endmodule
`default_nettype wire

// ==== verification/flash_write_enable_status_ctrl_tb.sv ====
// Purpose: both link ends driven over axi
// Assumes: 25 MHz core clock
// Notes:   short busy times except page write
`timescale 1ns/10ps
`default_nettype none
module flash_write_enable_status_ctrl_tb;
	import flash_pkg::*;
	localparam logic [7:0]  MFR = 8'h3c; // arbitrary
	localparam logic [15:0] DEV = 16'h0b1d; // arbitrary
	logic        clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, qm;
	logic [7:0]  awaddr, araddr, st;
	logic [31:0] wdata, rdata, rx;
	logic [1:0]  bresp, rresp;
	logic [3:0]  ws;
	int          n_fail, total_checks;
	flash_link_if link ();
	flash_host_ctrl flash_host_ctrl_i (.core_clk_in(clk), .sys_rst_in(rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(ws),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link));
	flash_wel_status_dev #(.SECTOR_T(1500), .HALF_T(40),
		.BLOCK_T(50), .CHIP_T(80), .STAT_T(1500), .MFR_ID(MFR),
		.DEV_ID(DEV)) flash_wel_status_dev_i (.core_clk_in(clk),
		.sys_rst_in(rst), .link(link), .status_out(st),
		.quad_mode_out(qm));
	flash_link_monitor flash_link_monitor_i (.core_clk_in(clk),
		.sys_rst_in(rst), .sel_n(link.sel_n), .wp_n(link.wp_n),
		.d_io_oe(link.d_io_oe), .status_out(st), .quad_mode_out(qm));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [31:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic op(input logic [15:0] c, input logic [31:0] t);
		logic [31:0] s;
		logic [1:0]  r;
		s = 32'h1;
		wr(REG_TXD, t);
		wr(REG_CMD, {16'h0, c});
		for (int i = 0; i < 3000 && s[0] !== 1'b0; i++)
			rd(REG_STAT, s, r);
		chk("engine idle", {31'h0, s[0]}, 32'h0);
		rd(REG_RXD, rx, r);
	endtask
	task automatic sr();
		op(16'h0805, 32'h0);
	endtask
	task automatic t_reset();
		logic [31:0] d;
		logic [1:0]  r;
		rd(8'h10, d, r);
		chk("unmapped", {30'h0, r}, 32'h2);
		sr();
		chk("reset status", rx & 32'hff, 32'h0);
	endtask
	task automatic t_latch();
		op(16'h0006, 32'h0);
		sr();
		chk("latch set", rx & 32'hff, 32'h2);
		op(16'h0004, 32'h0);
		sr();
		chk("latch clear", rx & 32'hff, 32'h0);
	endtask
	task automatic t_ident();
		op(16'h189f, 32'h0);
		chk("ident", rx & 32'hffffff, {8'h0, MFR, DEV});
		sr();
		chk("after ident", rx & 32'hff, 32'h0);
	endtask
	task automatic t_erase();
		op(16'h0320, 32'h0);
		sr();
		chk("erase refused", rx & 32'hff, 32'h0);
		op(16'h8320, 32'h0);
		sr();
		chk("erase busy", rx & 32'hff, 32'h3);
		op(16'h00b0, 32'h0);
		sr();
		chk("suspended", rx & 32'hff, 32'h0);
		op(16'h0030, 32'h0);
		sr();
		chk("resumed", rx & 32'hff, 32'h1);
		op(16'h4805, 32'h0);
		chk("erase done", rx & 32'hff, 32'h0);
	endtask
	task automatic t_swrite();
		op(16'h8101, 32'h1c000000);
		sr();
		chk("swr busy", rx & 32'hff, 32'h1f);
		op(16'h4805, 32'h0);
		chk("swr done", rx & 32'hff, 32'h1c);
		chk("status pins", {24'h0, st}, 32'h1c);
		op(16'h8320, 32'hf0000000);
		sr();
		chk("protected erase", rx & 32'hff, 32'h1e);
		op(16'h80c7, 32'h0);
		sr();
		chk("chip refused", rx & 32'hff, 32'h1e);
	endtask
	task automatic t_lock();
		logic [31:0] d;
		logic [1:0]  r;
		ws <= 4'he;
		wr(REG_STAT, 32'h0);
		ws <= 4'hf;
		rd(REG_STAT, d, r);
		chk("strobe off", d & 32'h2, 32'h2);
		wr(REG_STAT, 32'h0);
		rd(REG_STAT, d, r);
		chk("wp low", d & 32'h2, 32'h0);
		op(16'h8101, 32'h9c000000);
		op(16'h4805, 32'h0);
		chk("lock set", rx & 32'hff, 32'h9c);
		op(16'h8101, 32'h0);
		sr();
		chk("locked", rx & 32'hfd, 32'h9c);
		wr(REG_STAT, 32'h2);
		op(16'h8101, 32'h0);
		op(16'h4805, 32'h0);
		chk("unlocked", rx & 32'hff, 32'h0);
	endtask
	task automatic t_quad();
		op(16'h0035, 32'h0);
		chk("quad mode", {31'h0, qm}, 32'h1);
		op(16'h2006, 32'h0);
		op(16'h2805, 32'h0);
		chk("quad status", rx & 32'hff, 32'h2);
		op(16'h20f5, 32'h0);
		op(16'h0004, 32'h0);
		sr();
		chk("quad exit", rx & 32'hff, 32'h0);
	endtask
	task automatic conclude();
		if (n_fail == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#3000000;
		n_fail++;
		conclude();
	end
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		{awaddr, araddr, wdata} = 48'h0;
		ws = 4'hf;
		{n_fail, total_checks} = 64'h0;
		rst = 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_latch();
		t_ident();
		t_erase();
		t_swrite();
		t_lock();
		t_quad();
		conclude();
	end
endmodule
`default_nettype wire
